// >>> hbp_cpu_model.sv
// Processor bus master model driving the port pins
`timescale 1ns/10ps

module hbp_cpu_model
(
    input wire logic clock,
    input wire logic mode_strobes,
    input wire logic [15:0] data_out,
    input wire logic data_oe,
    output logic cs_n,
    output logic dir_wr_n,
    output logic oe_rd_n,
    output logic [11:0] addr,
    output logic [15:0] data
);
    logic rd_n = 1'h1;

    initial
    begin
        cs_n = 1'h1;
        dir_wr_n = 1'h1;
        addr = 12'h000;
        data = 16'h0000;
    end

    // Board ties the enable low in select mode
    assign oe_rd_n = mode_strobes ? rd_n : 1'h0;

    ////////////////////////////////////////
    task automatic run(input logic sel, input logic wr, input logic [11:0] a, input logic [15:0] d,
        output logic [15:0] q, output logic ok);
        int n;
        begin
            n = 0;
            @(negedge clock);
            addr = a;
            data = d;
            cs_n = ~sel;
            dir_wr_n = ~wr;
            rd_n = wr;
            do
            begin
                // Look at the answer mid-cycle, where the port's outputs have settled
                @(negedge clock);
                n++;
            end while ((wr || !sel) ? n < 6 : (data_oe !== 1'h1 && n < 20));
            ok = wr || !sel || data_oe === 1'h1;
            q = data_out;
            @(negedge clock);
            cs_n = 1'h1;
            dir_wr_n = 1'h1;
            rd_n = 1'h1;
            // Released lines show the inverse so stale values cannot pass
            addr = ~a;
            data = ~d;
            repeat (6) @(posedge clock);
        end
    endtask : run
endmodule : hbp_cpu_model

// >>> hbp_pkg.sv
// Types shared by the processor bus port modules
package hbp_pkg;

    // Bus cycle tracking of the port
    typedef enum logic [1:0]
    {
        HBP_IDLE,
        HBP_READ_WAIT,
        HBP_READ_HOLD,
        HBP_WRITE_HOLD
    } hbp_state_e;

    // Pin timing mode chosen by the board
    typedef enum logic
    {
        HBP_MODE_RW_SELECT,
        HBP_MODE_STROBES
    } hbp_mode_e;

endpackage : hbp_pkg

// >>> hbp_port.sv
// Processor bus slave port: pin decode, register access strobes, interrupt pin
//
// Overview of operation
// - Ignore the processor bus while select high; the cleared synchroniser still gives one write of 0 to address 0 after reset
// - Direction low writes, high reads, select mode
// - Low write strobe writes into the device
// - Low read strobe reads device onto bus
// - Pull interrupt low while condition pending
// - Sixteen-bit two-way data bus
// - Twelve-bit address selects register or location
`timescale 1ns/10ps
`include "hbp_port_regs.svh"

module hbp_port #(
    parameter int ADDR_W = `HBP_ADDR_W,
    parameter int DATA_W = `HBP_DATA_W
)
(
    input wire logic clock,
    input wire logic reset,
    input wire logic mode_strobes,
    input wire logic bus_cs_n,
    input wire logic bus_dir_wr_n,
    input wire logic bus_oe_rd_n,
    input wire logic [ADDR_W-1:0] bus_addr,
    input wire logic [DATA_W-1:0] bus_data_in,
    output logic [DATA_W-1:0] bus_data_out,
    output logic bus_data_oe,
    output logic bus_irq_out,
    output logic bus_irq_oe,
    output logic [ADDR_W-1:0] reg_addr,
    output logic [DATA_W-1:0] reg_wdata,
    output logic reg_wr,
    output logic reg_rd,
    input wire logic [DATA_W-1:0] reg_rdata,
    input wire logic irq_pending
);

    localparam int PIN_W = `HBP_CTRL_W + ADDR_W + DATA_W;

    ////////////////////////////////////////////////////////////////////////////////
    // Pin synchronisation

    hbp_sync_if #(.W(PIN_W)) pin_bus ();

    logic [DATA_W-1:0] data_s;
    logic [ADDR_W-1:0] addr_s;
    logic cs_n_s;
    logic dir_s;
    logic rd_n_s;
    hbp_pkg::hbp_mode_e mode;
    hbp_pkg::hbp_mode_e mode_raw;

    // Data and strobes share one synchroniser so they age together
    assign pin_bus.raw = {bus_cs_n, bus_dir_wr_n, bus_oe_rd_n, bus_addr, bus_data_in};

    hbp_sync #(.W(PIN_W), .STAGES(`HBP_SYNC_STAGES)) u_sync
    (
        .clock(clock),
        .reset(reset),
        .pins(pin_bus.sync)
    );

    assign data_s = pin_bus.synced[DATA_W-1:0];
    assign addr_s = pin_bus.synced[DATA_W +: ADDR_W];
    assign rd_n_s = pin_bus.synced[DATA_W + ADDR_W + `HBP_POS_RD];
    assign dir_s = pin_bus.synced[DATA_W + ADDR_W + `HBP_POS_DIR];
    assign cs_n_s = pin_bus.synced[DATA_W + ADDR_W + `HBP_POS_CS];

    // Mode strap is static board wiring; two flops guard against a slow ramp
    logic mode_meta;
    logic mode_sync;

    always_ff @(posedge clock or posedge reset)
    begin
        if (reset)
        begin
            mode_meta <= 1'h0;
            mode_sync <= 1'h0;
        end
        else
        begin
            mode_meta <= mode_strobes;
            mode_sync <= mode_meta;
        end
    end

    assign mode_raw = hbp_pkg::hbp_mode_e'(mode_sync);
    assign mode = mode_raw;

    ////////////////////////////////////////////////////////////////////////////////
    // Cycle decode

    logic want_read;
    logic want_write;

    always_comb
    begin
        want_read = 1'h0;
        want_write = 1'h0;
        if (!cs_n_s)
        begin
            if (mode == hbp_pkg::HBP_MODE_STROBES)
            begin
                want_read = !rd_n_s;
                want_write = !dir_s;
            end
            else
            begin
                // Output enable sits at ground here, but a read still needs it low as well as direction high
                want_read = dir_s && !rd_n_s;
                want_write = !dir_s;
            end
        end
    end

    ////////////////////////////////////////////////////////////////////////////////
    // Cycle state machine

    hbp_pkg::hbp_state_e state;
    hbp_pkg::hbp_state_e next_state;

    always_comb
    begin
        next_state = state;
        case (state)
            hbp_pkg::HBP_IDLE:
            begin
                if (want_read)
                begin
                    next_state = hbp_pkg::HBP_READ_WAIT;
                end
                else if (want_write)
                begin
                    next_state = hbp_pkg::HBP_WRITE_HOLD;
                end
            end
            hbp_pkg::HBP_READ_WAIT:
            begin
                next_state = hbp_pkg::HBP_READ_HOLD;
            end
            hbp_pkg::HBP_READ_HOLD:
            begin
                if (!want_read)
                begin
                    next_state = hbp_pkg::HBP_IDLE;
                end
            end
            hbp_pkg::HBP_WRITE_HOLD:
            begin
                if (!want_write)
                begin
                    next_state = hbp_pkg::HBP_IDLE;
                end
            end
            default:
            begin
                next_state = hbp_pkg::HBP_IDLE;
            end
        endcase
    end

    always_ff @(posedge clock or posedge reset)
    begin
        if (reset)
        begin
            state <= hbp_pkg::HBP_IDLE;
        end
        else
        begin
            state <= next_state;
        end
    end

    ////////////////////////////////////////////////////////////////////////////////
    // Register access strobes

    // A write commits on the trailing edge, so the last settled data wins
    always_ff @(posedge clock or posedge reset)
    begin
        if (reset)
        begin
            reg_addr <= `HBP_ADDR_RST;
            reg_wdata <= `HBP_DATA_RST;
            reg_wr <= 1'h0;
            reg_rd <= 1'h0;
        end
        else
        begin
            reg_wr <= (state == hbp_pkg::HBP_WRITE_HOLD) && !want_write;
            reg_rd <= (state == hbp_pkg::HBP_IDLE) && want_read;
            if ((state == hbp_pkg::HBP_IDLE) && (want_read || want_write))
            begin
                reg_addr <= addr_s;
            end
            if (want_write && (state == hbp_pkg::HBP_WRITE_HOLD || state == hbp_pkg::HBP_IDLE))
            begin
                reg_wdata <= data_s;
            end
        end
    end

    ////////////////////////////////////////////////////////////////////////////////
    // Read data and bus drive

    // Read data is held for the whole strobe; the core answers in the same cycle as reg_rd
    always_ff @(posedge clock or posedge reset)
    begin
        if (reset)
        begin
            bus_data_out <= `HBP_DATA_RST;
        end
        else if (state == hbp_pkg::HBP_READ_WAIT)
        begin
            bus_data_out <= reg_rdata;
        end
    end

    assign bus_data_oe = (state == hbp_pkg::HBP_READ_HOLD) && want_read;

    ////////////////////////////////////////////////////////////////////////////////
    // Interrupt pin

    always_ff @(posedge clock or posedge reset)
    begin
        if (reset)
        begin
            bus_irq_oe <= 1'h0;
        end
        else
        begin
            bus_irq_oe <= irq_pending;
        end
    end

    // Open drain: the pin only ever pulls low
    assign bus_irq_out = `HBP_IRQ_LEVEL;

    ////////////////////////////////////////////////////////////////////////////////
    // Assertions

    default clocking cb @(posedge clock); endclocking
    default disable iff (reset);

    a_cs_idle_ignore: assert property ((state == hbp_pkg::HBP_IDLE) && cs_n_s |=> !reg_rd && (state == hbp_pkg::HBP_IDLE))
        else $error("bus cycle accepted while chip select high");

    a_rw_mode_read: assert property ((state == hbp_pkg::HBP_IDLE) && (mode == hbp_pkg::HBP_MODE_RW_SELECT) && !cs_n_s
        && dir_s && !rd_n_s |=> reg_rd)
        else $error("direction high did not start a read");

    a_rw_mode_write: assert property ((state == hbp_pkg::HBP_IDLE) && !cs_n_s && !dir_s
        |=> (state == hbp_pkg::HBP_WRITE_HOLD) && !reg_rd)
        else $error("direction low did not start a write");

    a_write_commit: assert property ((state == hbp_pkg::HBP_WRITE_HOLD) && !want_write
        |=> reg_wr && (reg_wdata == $past(reg_wdata)) ##1 !reg_wr)
        else $error("write strobe release did not give one write pulse");

    a_strobe_read_data: assert property ((state == hbp_pkg::HBP_IDLE) && (mode == hbp_pkg::HBP_MODE_STROBES) && !cs_n_s
        && !rd_n_s |=> reg_rd ##1 (bus_data_out == $past(reg_rdata)))
        else $error("read strobe did not return core data");

    a_irq_follow: assert property (irq_pending |=> bus_irq_oe && !bus_irq_out)
        else $error("interrupt pin not pulled while pending");

    a_irq_release: assert property (!irq_pending |=> !bus_irq_oe)
        else $error("interrupt pin held without a pending condition");

    a_addr_capture: assert property (reg_rd |-> reg_addr == $past(addr_s))
        else $error("access address not taken from the bus");

    a_data_oe_only: assert property (bus_data_oe |-> !cs_n_s && want_read && ($past(state) != hbp_pkg::HBP_IDLE))
        else $error("data bus driven outside a selected read");

    a_data_stable: assert property (bus_data_oe && $past(bus_data_oe) |-> $stable(bus_data_out))
        else $error("read data changed while driven");

    c_read_cycle: cover property (reg_rd ##2 bus_data_oe);
    c_write_cycle: cover property ((state == hbp_pkg::HBP_WRITE_HOLD) ##1 reg_wr);
    c_irq_raise: cover property (!bus_irq_oe ##1 bus_irq_oe);
    c_back_to_back: cover property (reg_wr ##[1:4] reg_rd);

endmodule : hbp_port

// >>> hbp_port_regs.svh
// Widths, reset values and synchroniser depth for the processor bus port
`ifndef HBP_PORT_REGS_SVH
`define HBP_PORT_REGS_SVH

`define HBP_ADDR_W 12
`define HBP_DATA_W 16
`define HBP_CTRL_W 3
`define HBP_SYNC_STAGES 2
`define HBP_ADDR_RST 12'h000
`define HBP_DATA_RST 16'h0000
`define HBP_IRQ_LEVEL 1'h0

// Bit positions of the control strobes in the synchronised pin vector
`define HBP_POS_RD 0
`define HBP_POS_DIR 1
`define HBP_POS_CS 2

`endif

// >>> hbp_sync.sv
// Multi-stage synchroniser for asynchronous pin inputs
`timescale 1ns/10ps
`include "hbp_port_regs.svh"

module hbp_sync #(
    parameter int W = 1,
    parameter int STAGES = `HBP_SYNC_STAGES
)
(
    input wire logic clock,
    input wire logic reset,
    hbp_sync_if.sync pins
);

    // Only the last stage is visible; earlier stages may be metastable
    logic [W-1:0] stage [STAGES];

    always_ff @(posedge clock or posedge reset)
    begin
        if (reset)
        begin
            for (int i = 0; i < STAGES; i++)
            begin
                stage[i] <= '0;
            end
        end
        else
        begin
            stage[0] <= pins.raw;
            for (int i = 1; i < STAGES; i++)
            begin
                stage[i] <= stage[i-1];
            end
        end
    end

    assign pins.synced = stage[STAGES-1];

endmodule : hbp_sync

// >>> hbp_sync_if.sv
// Carrier for pin inputs on their way through the synchroniser
`timescale 1ns/10ps

interface hbp_sync_if #(
    parameter int W = 1
);
    logic [W-1:0] raw;
    logic [W-1:0] synced;

    modport src
    (
        output raw,
        input synced
    );

    modport sync
    (
        input raw,
        output synced
    );

endinterface : hbp_sync_if

// >>> tb.sv
// Self-checking bench for the processor bus port
`timescale 1ns/10ps

module tb;
    logic clock = 1'h0;
    logic reset = 1'h1;
    logic mode_strobes = 1'h0;
    logic irq_pending = 1'h0;
    logic cs_n, dir_wr_n, oe_rd_n, data_oe, irq_out, irq_oe, reg_wr, reg_rd, ok;
    logic [11:0] addr, reg_addr, wr_a;
    logic [15:0] data, data_out, reg_wdata, reg_rdata, q, wr_d;
    int fail_count = 0;
    int checks = 0;
    int wr_cnt = 0;
    int rd_cnt = 0;
    int oe_cnt = 0;

    always #5 clock = ~clock;
    // Core answer built from the address so each location reads distinct
    assign reg_rdata = {~reg_addr[3:0], reg_addr};

    // Count on the falling edge so the port's registered outputs are settled
    always @(negedge clock)
    begin
        if (reg_wr === 1'h1)
        begin
            wr_cnt++;
            wr_a = reg_addr;
            wr_d = reg_wdata;
        end
        if (reg_rd === 1'h1)
            rd_cnt++;
        if (data_oe === 1'h1)
            oe_cnt++;
    end

    hbp_port u_dut (.clock(clock), .reset(reset), .mode_strobes(mode_strobes), .bus_cs_n(cs_n),
        .bus_dir_wr_n(dir_wr_n), .bus_oe_rd_n(oe_rd_n), .bus_addr(addr), .bus_data_in(data),
        .bus_data_out(data_out), .bus_data_oe(data_oe), .bus_irq_out(irq_out), .bus_irq_oe(irq_oe),
        .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd),
        .reg_rdata(reg_rdata), .irq_pending(irq_pending));

    hbp_cpu_model u_cpu (.clock(clock), .mode_strobes(mode_strobes), .data_out(data_out),
        .data_oe(data_oe), .cs_n(cs_n), .dir_wr_n(dir_wr_n), .oe_rd_n(oe_rd_n), .addr(addr), .data(data));

    ////////////////////////////////////////
    task automatic chk(input logic [15:0] got, input logic [15:0] exp, input string what);
        begin
            checks++;
            if (got !== exp)
            begin
                fail_count++;
                $display("[ERR] %0t %s: got %h exp %h", $time, what, got, exp);
            end
        end
    endtask : chk

    task automatic report_and_stop();
        begin
            $display("checks %0d mismatches %0d", checks, fail_count);
            if (fail_count == 0 && checks > 0)
                $display("verification passed");
            else
                $display("verification failed");
            $finish;
        end
    endtask : report_and_stop

    task automatic t_access(input logic m, input logic [11:0] a, input logic [15:0] d);
        begin
            @(negedge clock);
            mode_strobes = m;
            repeat (4) @(negedge clock);
            wr_cnt = 0;
            rd_cnt = 0;
            oe_cnt = 0;
            u_cpu.run(1'h1, 1'h1, a, d, q, ok);
            chk(wr_cnt, 1, "write count");
            chk(wr_a, a, "write address");
            chk(wr_d, d, "write data");
            chk(oe_cnt, 0, "drive in write");
            u_cpu.run(1'h1, 1'h0, a, d, q, ok);
            chk(ok, 1, "read answer");
            if (ok !== 1'h1)
                report_and_stop();
            chk(rd_cnt, 1, "read count");
            chk(oe_cnt != 0, 1, "drive in read");
            chk(q, {~a[3:0], a}, "read data");
            chk(data_oe, 0, "drive after read");
            $display("test access mode %0d addr %h done", m, a);
        end
    endtask : t_access

    task automatic t_cs_high();
        begin
            wr_cnt = 0;
            rd_cnt = 0;
            oe_cnt = 0;
            u_cpu.run(1'h0, 1'h1, 12'h123, 16'h4321, q, ok);
            u_cpu.run(1'h0, 1'h0, 12'h123, 16'h4321, q, ok);
            chk(wr_cnt + rd_cnt, 0, "access while deselected");
            chk(oe_cnt, 0, "drive while deselected");
            $display("test deselect done");
        end
    endtask : t_cs_high

    task automatic t_irq();
        begin
            @(negedge clock);
            irq_pending = 1'h1;
            repeat (2) @(negedge clock);
            chk(irq_oe, 1, "irq pull");
            chk(irq_out, 0, "irq level");
            irq_pending = 1'h0;
            repeat (2) @(negedge clock);
            chk(irq_oe, 0, "irq release");
            $display("test irq done");
        end
    endtask : t_irq

    initial
    begin
        repeat (12) @(negedge clock);
        reset = 1'h0;
        repeat (4) @(negedge clock);
        chk(data_oe, 0, "drive after reset");
        t_access(1'h0, 12'hfff, 16'ha5c3);
        t_access(1'h1, 12'h000, 16'hffff);
        t_access(1'h1, 12'h5a3, 16'h0001);
        t_cs_high();
        t_access(1'h0, 12'h800, 16'h8000);
        t_irq();
        report_and_stop();
    end
endmodule : tb
